// File: include/ecc_pkg.sv
package ecc_pkg;

    // Each register is two 16-bit holding words: MS word at the offset, LS word at offset + 1.
    localparam logic [15:0] ADDR_SPEED_UNIT   = 16'h006A;
    localparam logic [15:0] ADDR_OPTIONS      = 16'h006C;
    localparam logic [15:0] ADDR_COMMAND      = 16'h006E;
    localparam logic [15:0] ADDR_STEPS_TURN   = 16'h0070;
    localparam logic [15:0] ADDR_TURN_COUNT   = 16'h0072;
    localparam logic [15:0] ADDR_ALARM_MASK   = 16'h0074;

    localparam logic [15:0] SPEED_UNIT_RST    = 16'h0000;
    localparam logic [15:0] SPEED_UNIT_MAX    = 16'h0001;
    localparam logic [15:0] OPTIONS_RST       = 16'h0000;
    localparam logic [15:0] OPTIONS_MAX       = 16'h0003;
    localparam logic [2:0]  COMMAND_RST       = 3'h0;
    localparam logic [15:0] ALARM_MASK_VAL    = 16'h7000;

    localparam int          OPT_SCALE_BIT     = 0;
    localparam int          OPT_DIR_BIT       = 1;
    localparam int          CMD_FIRST_BIT     = 9;
    localparam int          CMD_COUNT         = 3;
    localparam int          CMD_SAVE_IDX      = 0;
    localparam int          CMD_RESTORE_IDX   = 1;
    localparam int          CMD_PRESET_IDX    = 2;

    localparam int          STEPS_PER_TURN_DEF = 8192;
    localparam int          TURN_COUNT_DEF     = 16384;

    localparam int          CLK_HZ            = 40_000_000;
    localparam int          SPEED_PERIOD_MS   = 100;
    localparam int          SPEED_PERIOD_CYC  = CLK_HZ / 1000 * SPEED_PERIOD_MS;
    localparam int          WINDOWS_PER_SEC   = 1000 / SPEED_PERIOD_MS;
    localparam int          SEC_PER_MIN       = 60;

    typedef enum logic [0:0] {
        ECC_UNIT_STEPS_PER_S = 1'b0,
        ECC_UNIT_RPM         = 1'b1
    } ecc_unit_e;

endpackage : ecc_pkg

// File: rtl/ecc_edge.sv
`timescale 1ns/10ps
module ecc_edge
    import ecc_pkg::*;
#(
    parameter int W = CMD_COUNT
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_bits,
    output logic      [W-1:0] held_bits,
    output logic      [W-1:0] rise
);

    typedef struct packed {
        logic [W-1:0] held;
        logic [W-1:0] rise;
    } ecc_edge_s;

    ecc_edge_s    st_r;
    ecc_edge_s    st_nxt;
    logic [W-1:0] rise_w;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // A bit that stays high across writes never fires again.
            assign rise_w[i] = wr_en & wr_bits[i] & ~st_r.held[i];
        end
    endgenerate

    always_comb begin
        st_nxt      = st_r;
        st_nxt.rise = rise_w;
        if (wr_en) begin
            st_nxt.held = wr_bits;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign held_bits = st_r.held;
    assign rise      = st_r.rise;

endmodule : ecc_edge

// File: rtl/ecc_scale.sv
`timescale 1ns/10ps
module ecc_scale
    import ecc_pkg::*;
#(
    parameter int STEPS_PER_TURN = STEPS_PER_TURN_DEF,
    parameter int TURN_COUNT     = TURN_COUNT_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [31:0] raw_pos,
    input  wire logic        scale_en,
    input  wire logic        dir_ccw,
    input  wire logic [31:0] counts_per_turn,
    input  wire logic [31:0] total_resolution,
    input  wire logic [31:0] preset_value,
    input  wire logic        preset_fire,
    input  wire logic        restore_fire,
    output logic      [31:0] position_out,
    output logic      [31:0] offset_out
);

    localparam logic [63:0] HW_TOTAL = 64'(STEPS_PER_TURN) * 64'(TURN_COUNT);

    typedef struct packed {
        logic [31:0] pos;
        logic [31:0] offset;
    } ecc_scale_s;

    ecc_scale_s  st_r;
    ecc_scale_s  st_nxt;
    logic [31:0] dir_pos;
    logic [63:0] prod;
    logic [63:0] quot;
    logic [31:0] read_pos;

    always_comb begin
        // Counting down mirrors the code inside the physical range.
        dir_pos  = dir_ccw ? 32'(HW_TOTAL - 64'h1 - 64'(raw_pos)) : raw_pos;
        prod     = 64'(dir_pos) * 64'(counts_per_turn);
        quot     = prod / 64'(STEPS_PER_TURN);
        read_pos = dir_pos;
        if (scale_en) begin
            // Clamped rather than wrapped; a bad setting then shows as a stuck top value.
            if (quot >= 64'(total_resolution) && total_resolution != 32'h0) begin
                read_pos = total_resolution - 32'h1;
            end else begin
                read_pos = quot[31:0];
            end
        end
        st_nxt     = st_r;
        st_nxt.pos = read_pos + preset_value - st_r.offset;
        if (restore_fire) begin
            st_nxt.offset = 32'h0;
        end else if (preset_fire) begin
            st_nxt.offset = read_pos;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign position_out = st_r.pos;
    assign offset_out   = st_r.offset;

endmodule : ecc_scale

// File: rtl/ecc_regs.sv
`timescale 1ns/10ps
module ecc_regs
    import ecc_pkg::*;
#(
    parameter int STEPS_PER_TURN      = STEPS_PER_TURN_DEF,
    parameter int TURN_COUNT          = TURN_COUNT_DEF,
    parameter int SPEED_PERIOD_CYCLES = SPEED_PERIOD_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [15:0] hr_addr,
    input  wire logic        hr_wr,
    input  wire logic [15:0] hr_wdata,
    input  wire logic        hr_rd,
    output logic      [15:0] hr_rdata,
    output logic             hr_ack,
    output logic             hr_exc,
    input  wire logic [31:0] sensor_position,
    input  wire logic [31:0] counts_per_turn,
    input  wire logic [31:0] total_resolution,
    input  wire logic [31:0] preset_value,
    output logic      [31:0] position_out,
    output logic      [31:0] offset_out,
    output logic      [31:0] speed_out,
    output logic      [7:0]  status_byte,
    output logic             scale_en,
    output logic             dir_ccw,
    output logic             nv_save,
    output logic             nv_restore
);

    localparam logic [31:0] STEPS_VAL = 32'(STEPS_PER_TURN);
    localparam logic [31:0] TURNS_VAL = 32'(TURN_COUNT);
    localparam logic [31:0] TIMER_TOP = 32'(SPEED_PERIOD_CYCLES - 1);

    typedef struct packed {
        logic [31:0] pos_s1;
        logic [31:0] pos_s2;
        logic        unit;
        logic [1:0]  opts;
        logic [15:0] rdata;
        logic        ack;
        logic        exc;
        logic [31:0] timer;
        logic [31:0] pos_prev;
        logic [31:0] speed;
    } ecc_regs_s;

    ecc_regs_s          st_r;
    ecc_regs_s          st_nxt;
    logic [CMD_COUNT-1:0] cmd_held;
    logic [CMD_COUNT-1:0] cmd_rise;
    logic                 cmd_wr;
    logic [1:0]           hit_unit;
    logic [1:0]           hit_opts;
    logic [1:0]           hit_cmd;
    logic [1:0]           hit_steps;
    logic [1:0]           hit_turns;
    logic [1:0]           hit_alarm;
    logic signed [63:0]   delta;
    logic signed [63:0]   speed_calc;

    // Returns {MS word hit, LS word hit} for a two-word register at base.
    function automatic logic [1:0] word_hit(input logic [15:0] addr,
                                            input logic [15:0] base);
        word_hit = {addr == base, addr == base + 16'h0001};
    endfunction : word_hit

    always_comb begin
        hit_unit  = word_hit(hr_addr, ADDR_SPEED_UNIT);
        hit_opts  = word_hit(hr_addr, ADDR_OPTIONS);
        hit_cmd   = word_hit(hr_addr, ADDR_COMMAND);
        hit_steps = word_hit(hr_addr, ADDR_STEPS_TURN);
        hit_turns = word_hit(hr_addr, ADDR_TURN_COUNT);
        hit_alarm = word_hit(hr_addr, ADDR_ALARM_MASK);
    end

    // Only bits 9 to 11 of the LS word reach the edge finder; all else is dropped.
    assign cmd_wr = hr_wr & hit_cmd[0];

    ecc_edge #(
        .W (CMD_COUNT)
    ) u_edge (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .wr_en     (cmd_wr),
        .wr_bits   (hr_wdata[CMD_FIRST_BIT +: CMD_COUNT]),
        .held_bits (cmd_held),
        .rise      (cmd_rise)
    );

    ecc_scale #(
        .STEPS_PER_TURN (STEPS_PER_TURN),
        .TURN_COUNT     (TURN_COUNT)
    ) u_scale (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .raw_pos          (st_r.pos_s2),
        .scale_en         (st_r.opts[OPT_SCALE_BIT]),
        .dir_ccw          (st_r.opts[OPT_DIR_BIT]),
        .counts_per_turn  (counts_per_turn),
        .total_resolution (total_resolution),
        .preset_value     (preset_value),
        .preset_fire      (cmd_rise[CMD_PRESET_IDX]),
        .restore_fire     (cmd_rise[CMD_RESTORE_IDX]),
        .position_out     (position_out),
        .offset_out       (offset_out)
    );

    // The speed is the position change over one window, scaled to the chosen unit.
    always_comb begin
        delta = 64'(signed'(position_out - st_r.pos_prev));
        if (st_r.unit == ECC_UNIT_RPM) begin
            speed_calc = delta * 64'(WINDOWS_PER_SEC * SEC_PER_MIN)
                         / 64'(STEPS_PER_TURN);
        end else begin
            speed_calc = delta * 64'(WINDOWS_PER_SEC);
        end
    end

    always_comb begin
        st_nxt        = st_r;
        // The sensor word is sampled twice before use; the source must hold it stable.
        st_nxt.pos_s1 = sensor_position;
        st_nxt.pos_s2 = st_r.pos_s1;
        st_nxt.ack    = hr_wr | hr_rd;
        st_nxt.exc    = 1'b0;
        st_nxt.rdata  = 16'h0000;

        if (hr_rd) begin
            if (hit_unit[0]) begin
                st_nxt.rdata = {15'h0000, st_r.unit};
            end else if (hit_opts[0]) begin
                st_nxt.rdata = {14'h0000, st_r.opts};
            end else if (hit_cmd[0]) begin
                st_nxt.rdata = {4'h0, cmd_held, 9'h000};
            end else if (hit_steps[1]) begin
                st_nxt.rdata = STEPS_VAL[31:16];
            end else if (hit_steps[0]) begin
                st_nxt.rdata = STEPS_VAL[15:0];
            end else if (hit_turns[1]) begin
                st_nxt.rdata = TURNS_VAL[31:16];
            end else if (hit_turns[0]) begin
                st_nxt.rdata = TURNS_VAL[15:0];
            end else if (hit_alarm[0]) begin
                st_nxt.rdata = ALARM_MASK_VAL;
            end else if (hit_unit[1] | hit_opts[1] | hit_cmd[1] | hit_alarm[1]) begin
                st_nxt.rdata = 16'h0000;
            end else begin
                st_nxt.exc = 1'b1;
            end
        end else if (hr_wr) begin
            if (hit_unit[0]) begin
                if (hr_wdata <= SPEED_UNIT_MAX) begin
                    st_nxt.unit = hr_wdata[0];
                end else begin
                    st_nxt.exc = 1'b1;
                end
            end else if (hit_opts[0]) begin
                if (hr_wdata <= OPTIONS_MAX) begin
                    st_nxt.opts = hr_wdata[1:0];
                end else begin
                    st_nxt.exc = 1'b1;
                end
            end else if (hit_cmd[0] | hit_cmd[1] | hit_unit[1] | hit_opts[1]) begin
                st_nxt.exc = 1'b0;
            end else begin
                // Read-only and unmapped words refuse writes.
                st_nxt.exc = 1'b1;
            end
        end

        // Restore wins over an option write in the same cycle as its pulse, which comes a cycle after the command write.
        if (cmd_rise[CMD_RESTORE_IDX]) begin
            st_nxt.unit = SPEED_UNIT_RST[0];
            st_nxt.opts = OPTIONS_RST[1:0];
        end

        if (st_r.timer >= TIMER_TOP) begin
            st_nxt.timer    = 32'h0;
            st_nxt.pos_prev = position_out;
            st_nxt.speed    = speed_calc[31:0];
        end else begin
            st_nxt.timer = st_r.timer + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hr_rdata    = st_r.rdata;
    assign hr_ack      = st_r.ack;
    assign hr_exc      = st_r.exc;
    assign speed_out   = st_r.speed;
    assign status_byte = {6'h00, st_r.opts};
    assign scale_en    = st_r.opts[OPT_SCALE_BIT];
    assign dir_ccw     = st_r.opts[OPT_DIR_BIT];
    // The store only counts this pulse; the offset never reaches it.
    assign nv_save     = cmd_rise[CMD_SAVE_IDX];
    assign nv_restore  = cmd_rise[CMD_RESTORE_IDX];

endmodule : ecc_regs

// File: verif/ecc_regs_props.sv
`timescale 1ns/10ps
module ecc_regs_props
    import ecc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [15:0] hr_addr,
    input wire logic        hr_wr,
    input wire logic [15:0] hr_wdata,
    input wire logic        hr_rd,
    input wire logic [15:0] hr_rdata,
    input wire logic        hr_ack,
    input wire logic        hr_exc,
    input wire logic [31:0] preset_value,
    input wire logic [31:0] position_out,
    input wire logic [7:0]  status_byte,
    input wire logic        scale_en,
    input wire logic        dir_ccw,
    input wire logic        nv_save,
    input wire logic        nv_restore
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic [2:0] cmd_r;
    logic [1:0] opt_r;
    logic       cmd_wr;
    logic       opt_wr;
    assign cmd_wr = hr_wr && hr_addr == ADDR_COMMAND + 16'h0001;
    assign opt_wr = hr_wr && hr_addr == ADDR_OPTIONS + 16'h0001;

    // Shadow of the stored command bits, so edges are judged against the last write.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= 3'h0;
        end else if (cmd_wr) begin
            cmd_r <= hr_wdata[11:9];
        end
    end

    // Shadow of the accepted options; a restore pulse wins over a write in the same cycle.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            opt_r <= 2'h0;
        end else if (nv_restore) begin
            opt_r <= OPTIONS_RST[1:0];
        end else if (opt_wr && hr_wdata <= OPTIONS_MAX) begin
            opt_r <= hr_wdata[1:0];
        end
    end

    ack_after_req_a: assert property ((hr_wr || hr_rd) |=> hr_ack)
        else $error("no answer one cycle after a request");
    ack_has_cause_a: assert property (hr_ack |-> $past(hr_wr || hr_rd))
        else $error("answer without a request");
    opt_write_a: assert property (opt_wr && hr_wdata <= OPTIONS_MAX |=>
        {dir_ccw, scale_en} == $past(hr_wdata[1:0])) else $error("options not taken");
    opt_refuse_a: assert property (opt_wr && hr_wdata > OPTIONS_MAX |=>
        hr_exc && $stable({dir_ccw, scale_en})) else $error("bad options taken");
    status_mirror_a: assert property (status_byte == {6'h00, opt_r}
        && {dir_ccw, scale_en} == opt_r) else $error("status byte differs from options");
    save_edge_a: assert property (nv_save == $past(cmd_wr && hr_wdata[9] && !cmd_r[0]))
        else $error("save pulse wrong");
    restore_edge_a: assert property (nv_restore == $past(cmd_wr && hr_wdata[10] && !cmd_r[1]))
        else $error("restore pulse wrong");
    preset_apply_a: assert property (cmd_wr && hr_wdata[11] && !hr_wdata[10] && !cmd_r[2]
        |-> ##3 position_out == preset_value) else $error("preset not applied");
    ro_refuse_a: assert property (hr_wr && hr_addr >= ADDR_STEPS_TURN
        && hr_addr <= ADDR_ALARM_MASK + 16'h0001 |=> hr_exc) else $error("read-only write taken");
    alarm_read_a: assert property (hr_rd && hr_addr == ADDR_ALARM_MASK + 16'h0001
        |=> hr_rdata == ALARM_MASK_VAL && !hr_exc) else $error("alarm mask wrong");

    cover property (nv_save);
    cover property (nv_restore);
    cover property (hr_ack && hr_exc);
endmodule : ecc_regs_props

// File: verif/ecc_store.sv
`timescale 1ns/10ps
module ecc_store
    import ecc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nv_save,
    input  wire logic        nv_restore,
    output logic      [31:0] counts_per_turn,
    output logic      [31:0] total_resolution,
    output logic      [31:0] preset_value
);
    int save_cnt = 0;

    initial begin
        counts_per_turn = 32'(STEPS_PER_TURN_DEF);
        total_resolution = 32'(STEPS_PER_TURN_DEF * TURN_COUNT_DEF);
        preset_value = 32'h0000_0000;
    end

    task automatic set_p(input logic [31:0] c, input logic [31:0] t, input logic [31:0] p);
        counts_per_turn <= c;
        total_resolution <= t;
        preset_value <= p;
    endtask : set_p

    always @(posedge clk_sys) begin
        if (nv_save) begin
            save_cnt++;
        end
        if (nv_restore) begin
            counts_per_turn <= 32'(STEPS_PER_TURN_DEF);
            total_resolution <= 32'(STEPS_PER_TURN_DEF * TURN_COUNT_DEF);
            preset_value <= 32'h0000_0000;
        end
    end
endmodule : ecc_store

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import ecc_pkg::*;
();
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hr_wr = 1'b0;
    logic        hr_rd = 1'b0;
    logic [15:0] hr_addr = 16'h0000;
    logic [15:0] hr_wdata = 16'h0000;
    logic [31:0] sensor_position = 32'h0000_0000;
    logic [31:0] cpt, tres, pval, position_out, offset_out, speed_out;
    logic [15:0] hr_rdata, data_s;
    logic [7:0]  status_byte;
    logic        hr_ack, hr_exc, scale_en, dir_ccw, nv_save, nv_restore, exc_s, save_s, rest_s;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;

    ecc_regs #(.SPEED_PERIOD_CYCLES(20)) i_ecc_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hr_addr(hr_addr), .hr_wr(hr_wr), .hr_wdata(hr_wdata), .hr_rd(hr_rd),
        .hr_rdata(hr_rdata), .hr_ack(hr_ack), .hr_exc(hr_exc),
        .sensor_position(sensor_position), .counts_per_turn(cpt), .total_resolution(tres),
        .preset_value(pval), .position_out(position_out), .offset_out(offset_out),
        .speed_out(speed_out), .status_byte(status_byte), .scale_en(scale_en), .dir_ccw(dir_ccw),
        .nv_save(nv_save), .nv_restore(nv_restore));
    ecc_store i_ecc_store (.clk_sys(clk_sys), .nv_save(nv_save), .nv_restore(nv_restore),
        .counts_per_turn(cpt), .total_resolution(tres), .preset_value(pval));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // One request, then the answer is taken in the single cycle that it stands.
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        hr_addr <= a;
        hr_wdata <= d;
        hr_wr <= w;
        hr_rd <= !w;
        @(posedge clk_sys);
        hr_wr <= 1'b0;
        hr_rd <= 1'b0;
        #1;
        chk(hr_ack, 1'b1);
        exc_s = hr_exc;
        data_s = hr_rdata;
        save_s = nv_save;
        rest_s = nv_restore;
    endtask : access

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        access(1'b1, a, d);
        chk(exc_s, e);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] v, input logic e);
        access(1'b0, a, 16'h0000);
        chk(exc_s, e);
        chk(data_s, v);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle

    task automatic t_basic();
        rd(16'h006B, 16'h0000, 1'b0);
        rd(16'h006D, 16'h0000, 1'b0);
        rd(16'h006A, 16'h0000, 1'b0);
        for (int v = 0; v < 3; v++) begin
            wr(16'h006B, 16'(v), v > 1);
            rd(16'h006B, (v > 1) ? 16'h0001 : 16'(v), 1'b0);
        end
        for (int v = 0; v < 5; v++) begin
            wr(16'h006D, 16'(v), v > 3);
            chk({dir_ccw, scale_en}, (v > 3) ? 2'h3 : 2'(v));
            chk(status_byte, (v > 3) ? 8'h03 : 8'(v));
        end
        wr(16'h006D, 16'h0000, 1'b0);
    endtask : t_basic

    task automatic t_ro();
        logic [15:0] vals [6] = '{16'h0000, 16'h2000, 16'h0000, 16'h4000, 16'h0000, 16'h7000};
        for (int i = 0; i < 6; i++) begin
            rd(16'h0070 + 16'(i), vals[i], 1'b0);
        end
        wr(16'h0071, 16'h0100, 1'b1);
        rd(16'h0071, 16'h2000, 1'b0);
        rd(16'h0080, 16'h0000, 1'b1);
    endtask : t_ro

    task automatic t_cmd();
        wr(16'h006F, 16'h0200, 1'b0);
        chk(save_s, 1'b1);
        wr(16'h006F, 16'h0200, 1'b0);
        chk(save_s, 1'b0);
        wr(16'h006F, 16'h0000, 1'b0);
        wr(16'h006F, 16'h0200, 1'b0);
        chk(save_s, 1'b1);
        wr(16'h006F, 16'hF1FF, 1'b0);
        chk({save_s, rest_s}, 2'h0);
        rd(16'h006F, 16'h0000, 1'b0);
        chk(i_ecc_store.save_cnt, 2);
    endtask : t_cmd

    task automatic t_preset();
        sensor_position <= 32'd1000;
        i_ecc_store.set_p(32'd8192, 32'h0800_0000, 32'd50);
        idle(6);
        wr(16'h006F, 16'h0800, 1'b0);
        idle(3);
        chk(position_out, 32'd50);
        chk(offset_out, 32'd1000);
        chk(i_ecc_store.save_cnt, 2);
        sensor_position <= 32'd1001;
        idle(5);
        chk(position_out, 32'd51);
        wr(16'h006F, 16'h0000, 1'b0);
        wr(16'h006F, 16'h0200, 1'b0);
        chk(save_s, 1'b1);
        // The store counts the pulse on the edge that ends it, one cycle after the answer.
        idle(1);
        chk(i_ecc_store.save_cnt, 3);
    endtask : t_preset

    task automatic t_restore();
        wr(16'h006B, 16'h0001, 1'b0);
        wr(16'h006D, 16'h0003, 1'b0);
        wr(16'h006F, 16'h0400, 1'b0);
        chk(rest_s, 1'b1);
        idle(1);
        chk(offset_out, 32'd0);
        rd(16'h006B, 16'h0000, 1'b0);
        rd(16'h006D, 16'h0000, 1'b0);
        wr(16'h006F, 16'h0000, 1'b0);
    endtask : t_restore

    // The scaled figures are picked so that the division is exact, leaving no rounding doubt.
    task automatic t_scale();
        i_ecc_store.set_p(32'd2048, 32'd100000, 32'd0);
        sensor_position <= 32'd4000;
        wr(16'h006D, 16'h0001, 1'b0);
        idle(6);
        chk(position_out, 32'd1000);
        i_ecc_store.set_p(32'd2048, 32'd500, 32'd0);
        idle(6);
        chk(position_out, 32'd499);
        wr(16'h006D, 16'h0002, 1'b0);
        idle(6);
        chk(position_out, 32'h0800_0000 - 32'd4001);
    endtask : t_scale

    // The window phase is unknown here, so each step is waited for up to 50 cycles, two and a half windows.
    task automatic wait_speed(input logic [31:0] exp);
        for (int n = 0; n < 50 && speed_out !== exp; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(speed_out, exp);
    endtask : wait_speed

    // One physical turn in one window is 81920 steps/s or 600 rpm.
    task automatic t_speed();
        wr(16'h006D, 16'h0000, 1'b0);
        idle(50);
        chk(speed_out, 32'h0000_0000);
        sensor_position <= 32'd12192;
        wait_speed(32'd81920);
        wr(16'h006B, 16'h0001, 1'b0);
        sensor_position <= 32'd4000;
        wait_speed(32'hFFFF_FDA8);
    endtask : t_speed

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_basic();
        t_ro();
        t_cmd();
        t_preset();
        t_restore();
        t_scale();
        t_speed();
        results();
    end
endmodule : tb_top

bind ecc_regs ecc_regs_props i_ecc_regs_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hr_addr(hr_addr), .hr_wr(hr_wr), .hr_wdata(hr_wdata), .hr_rd(hr_rd),
    .hr_rdata(hr_rdata), .hr_ack(hr_ack), .hr_exc(hr_exc), .preset_value(preset_value),
    .position_out(position_out), .status_byte(status_byte), .scale_en(scale_en),
    .dir_ccw(dir_ccw), .nv_save(nv_save), .nv_restore(nv_restore));
